/* File: core/crpm_core_regs.sv */
// Core architectural registers and power control, reached over Avalon-MM.
//
// Function
// - Stack pointer resets 0x07, increments before push.
// - Low and high bytes form 16-bit pointer.
// - Carry bit 7 follows arithmetic carry/borrow.
// - Half carry bit 6 follows nibble carry.
// - Bank select bits 4:3 choose register bank.
// - Overflow set on signed, multiply, divide faults.
// - Overflow cleared when those operations don't overflow.
// - Parity bit 0 is accumulator odd parity.
// - User flags bits 5,1 are software-only.
// - Second accumulator at 0xF0, resets zero.
// - Idle bit halts core after instruction.
// - Registers hold their values while idle; the stack pointer, pointer bytes and clock-loss enable still take bus writes.
// - Enabled interrupt ends idle, core resumes.
// - Reset during idle restarts at 0x0000.
// - Watchdog reset still ends idle.
// - Stop bit halts everything after instruction.
// - Stop ends only by reset.
// - Stop and idle bits always read 0.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module crpm_core_regs (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [crpm_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  input wire crpm_pkg::crpm_arith_t arith_in,
  input wire crpm_pkg::crpm_core_ev_t core_ev_in,
  output logic [15:0] indirect_pointer16_out,
  output logic [4:0] bank_base_out,
  output logic [7:0] push_addr_out,
  output logic push_ack_out,
  output logic core_halt_out,
  output logic osc_stop_out,
  output logic core_reset_req_out,
  output logic [15:0] restart_pc_out
);
  import crpm_pkg::*;

  logic [7:0] stack_top_pointer;
  logic [7:0] pointer_low_byte;
  logic [7:0] pointer_high_byte;
  logic [7:0] main_accumulator;
  logic [7:0] second_accumulator;
  logic carry_flag;
  logic half_carry_flag;
  logic user_flag_a;
  logic user_flag_b;
  logic bank_select_high;
  logic bank_select_low;
  logic overflow_flag;
  logic parity_flag;
  logic ack;
  logic wr_hit;
  logic [7:0] wr_byte;
  logic [7:0] idx;
  logic bad_addr;
  logic [7:0] rd_byte;
  logic idle_req;
  logic stop_req;
  logic idle_pending;
  logic halted;
  crpm_pwr_t pwr_state;
  logic clock_loss_enable;

  // Byte address to register index; the two low address bits are ignored.
  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction : word_index

  // Odd parity of one byte.
  function automatic logic odd_parity(input logic [7:0] v);
    return ^v;
  endfunction : odd_parity

  assign idx = word_index(avs_address_in);
  assign wr_byte = avs_writedata_in[7:0];
  // A write lands only when lane zero is enabled and the slave acknowledges.
  assign wr_hit = avs_write_in && ack && avs_byteenable_in[0];
  assign halted = (pwr_state != CRPM_RUN);

  // Address decode for reads and the error answer.
  always_comb begin
    bad_addr = 1'b0;
    rd_byte = RST_ZERO;
    if (idx == IDX_STACK_TOP) begin
      rd_byte = stack_top_pointer;
    end else if (idx == IDX_PTR_LOW) begin
      rd_byte = pointer_low_byte;
    end else if (idx == IDX_PTR_HIGH) begin
      rd_byte = pointer_high_byte;
    end else if (idx == IDX_POWER_CONTROL) begin
      rd_byte = RST_ZERO;
    end else if (idx == IDX_STATUS_WORD) begin
      rd_byte = {carry_flag, half_carry_flag, user_flag_a, bank_select_high,
                 bank_select_low, overflow_flag, user_flag_b, parity_flag};
    end else if (idx == IDX_MAIN_ACC) begin
      rd_byte = main_accumulator;
    end else if (idx == IDX_SECOND_ACC) begin
      rd_byte = second_accumulator;
    end else if (idx == IDX_POWER_STATE) begin
      rd_byte = {5'h00, clock_loss_enable, pwr_state};
    end else begin
      bad_addr = 1'b1;
    end
  end

  // Every request is held one cycle in waitrequest, then answered.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_in || avs_write_in) && !ack;
    end
  end

  // Waitrequest is its own flop, the inverse of the acknowledge, so no gate sits on the pin.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack);
    end
  end

  // Read data and response are registered together with the acknowledge.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'h0;
    end else if ((avs_read_in || avs_write_in) && !ack) begin
      avs_readdata_out <= {24'h00_0000, rd_byte};
      avs_response_out <= bad_addr ? 2'h2 : 2'h0;
    end
  end

  // Stack pointer: a push bumps it first, then the byte goes to the new top.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stack_top_pointer <= RST_STACK_TOP;
      push_addr_out <= RST_ZERO;
      push_ack_out <= 1'b0;
    end else begin
      push_ack_out <= 1'b0;
      if (wr_hit && idx == IDX_STACK_TOP) begin
        stack_top_pointer <= wr_byte;
      end else if (core_ev_in.push && !halted) begin
        stack_top_pointer <= stack_top_pointer + 8'h01;
        push_addr_out <= stack_top_pointer + 8'h01;
        push_ack_out <= 1'b1;
      end
    end
  end

  // Data pointer bytes.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pointer_low_byte <= RST_ZERO;
      pointer_high_byte <= RST_ZERO;
    end else begin
      if (wr_hit && idx == IDX_PTR_LOW) begin
        pointer_low_byte <= wr_byte;
      end
      if (wr_hit && idx == IDX_PTR_HIGH) begin
        pointer_high_byte <= wr_byte;
      end
    end
  end

  // Accumulators; a datapath result overrides a bus write in the same cycle.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_accumulator <= RST_ZERO;
      second_accumulator <= RST_ZERO;
    end else if (arith_in.valid && !halted) begin
      main_accumulator <= arith_in.acc;
      if (arith_in.op == CRPM_OP_MUL || arith_in.op == CRPM_OP_DIV) begin
        second_accumulator <= arith_in.second;
      end
    end else if (!halted) begin
      if (wr_hit && idx == IDX_MAIN_ACC) begin
        main_accumulator <= wr_byte;
      end
      if (wr_hit && idx == IDX_SECOND_ACC) begin
        second_accumulator <= wr_byte;
      end
    end
  end

  // Arithmetic flags: carries from the datapath, overflow per operation class.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      carry_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (arith_in.valid && !halted) begin
      if (arith_in.op != CRPM_OP_NONE) begin
        carry_flag <= (arith_in.op == CRPM_OP_ADD || arith_in.op == CRPM_OP_ADDC ||
                       arith_in.op == CRPM_OP_SUBB) && arith_in.carry;
        half_carry_flag <= (arith_in.op == CRPM_OP_ADD || arith_in.op == CRPM_OP_ADDC ||
                            arith_in.op == CRPM_OP_SUBB) && arith_in.half;
      end
      if (arith_in.op inside {CRPM_OP_ADD, CRPM_OP_ADDC, CRPM_OP_SUBB, CRPM_OP_MUL, CRPM_OP_DIV}) begin
        overflow_flag <= arith_in.ovf_cond;
      end
    end else if (wr_hit && idx == IDX_STATUS_WORD && !halted) begin
      carry_flag <= wr_byte[SW_CARRY];
      half_carry_flag <= wr_byte[SW_HALF];
      overflow_flag <= wr_byte[SW_OVF];
    end
  end

  // User flags and bank select are software only; hardware never moves them.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      user_flag_a <= 1'b0;
      user_flag_b <= 1'b0;
      bank_select_high <= 1'b0;
      bank_select_low <= 1'b0;
    end else if (wr_hit && idx == IDX_STATUS_WORD && !halted) begin
      user_flag_a <= wr_byte[SW_USER_A];
      user_flag_b <= wr_byte[SW_USER_B];
      bank_select_high <= wr_byte[SW_BANK_HI];
      bank_select_low <= wr_byte[SW_BANK_LO];
    end
  end

  // Parity is kept in a flop so it can be read as part of the status word.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      parity_flag <= 1'b0;
    end else begin
      parity_flag <= odd_parity(next_acc_value());
    end
  end

  // Accumulator value after this edge, so parity never lags it.
  function automatic logic [7:0] next_acc_value();
    if (arith_in.valid && !halted) begin
      return arith_in.acc;
    end else if (wr_hit && idx == IDX_MAIN_ACC && !halted) begin
      return wr_byte;
    end
    return main_accumulator;
  endfunction : next_acc_value

  // Pointer and bank outputs, registered.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      indirect_pointer16_out <= 16'h0000;
      bank_base_out <= 5'h00;
    end else begin
      indirect_pointer16_out <= {pointer_high_byte, pointer_low_byte};
      bank_base_out <= 5'({bank_select_high, bank_select_low}) * BANK_SIZE;
    end
  end

  // Power control writes become one-cycle requests; the bits never store.
  assign idle_req = wr_hit && idx == IDX_POWER_CONTROL && wr_byte[PC_IDLE];
  assign stop_req = wr_hit && idx == IDX_POWER_CONTROL && wr_byte[PC_STOP];

  // Clock-loss detector enable lives in the power state register.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_loss_enable <= 1'b0;
    end else if (wr_hit && idx == IDX_POWER_STATE) begin
      clock_loss_enable <= wr_byte[PS_LOSS_EN];
    end
  end

  crpm_power_fsm u_power (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .idle_req_in(idle_req),
    .stop_req_in(stop_req),
    .instr_done_in(core_ev_in.instr_done),
    .irq_pending_in(core_ev_in.irq_pending),
    .state_out(pwr_state),
    .idle_armed_out(idle_pending)
  );

  // Halt and oscillator outputs; a reset request from the watchdog or clock
  // detector is passed out so the reset generator ends idle or stop.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_halt_out <= 1'b0;
      osc_stop_out <= 1'b0;
      core_reset_req_out <= 1'b0;
      restart_pc_out <= RST_RESTART_PC;
    end else begin
      core_halt_out <= (pwr_state != CRPM_RUN);
      osc_stop_out <= (pwr_state == CRPM_STOP);
      core_reset_req_out <= core_ev_in.watchdog_reset ||
                            (core_ev_in.clock_loss_reset && clock_loss_enable);
    end
  end

  // Stop may not be left by an interrupt.
  a_stop_sticky: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    pwr_state == CRPM_STOP |=> pwr_state == CRPM_STOP)
    else $error("stop left without reset");
  // Interrupt in idle returns to run.
  a_idle_wake: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    pwr_state == CRPM_IDLE && core_ev_in.irq_pending |=> pwr_state == CRPM_RUN)
    else $error("idle not ended by interrupt");
  // Power bits read zero.
  a_power_control_reads: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    avs_read_in && !ack && idx == IDX_POWER_CONTROL |=> avs_readdata_out == 32'h0)
    else $error("power control read nonzero");
  // Push increments the pointer by one.
  a_push_incr: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    core_ev_in.push && !halted && !(wr_hit && idx == IDX_STACK_TOP)
    |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01 && push_addr_out == stack_top_pointer)
    else $error("push did not pre-increment");
  // Parity tracks the accumulator.
  a_parity_acc: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    parity_flag == ^main_accumulator)
    else $error("parity mismatch");
  // Main accumulator, carry and overflow hold while halted.
  a_idle_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    halted |=> $stable(main_accumulator) && $stable(carry_flag) && $stable(overflow_flag))
    else $error("register changed while halted");
  // Overflow follows the condition for add, multiply and divide.
  a_ovf_follow: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    arith_in.valid && !halted && arith_in.op inside {CRPM_OP_ADD, CRPM_OP_MUL, CRPM_OP_DIV}
    |=> overflow_flag == $past(arith_in.ovf_cond))
    else $error("overflow flag wrong");
  // Stop wins over idle.
  a_stop_wins: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    pwr_state == CRPM_RUN && stop_req && core_ev_in.instr_done |=> pwr_state == CRPM_STOP)
    else $error("stop did not win");
  // Pointer output pairs high and low bytes.
  a_pointer_pair: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    1'b1 |=> indirect_pointer16_out == {$past(pointer_high_byte), $past(pointer_low_byte)})
    else $error("pointer pairing wrong");
  // An armed request leaves run when the instruction ends.
  a_armed_enter: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    pwr_state == CRPM_RUN && idle_pending && core_ev_in.instr_done |=> pwr_state != CRPM_RUN)
    else $error("armed power request not taken");
  // User flags move only by a status word write.
  a_user_hold: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
    !(wr_hit && idx == IDX_STATUS_WORD && !halted) |=> $stable(user_flag_a) && $stable(user_flag_b))
    else $error("user flag changed without write");
endmodule : crpm_core_regs

/* File: core/crpm_pkg.sv */
// Package of register offsets, field positions, reset values and types for the core register block.
package crpm_pkg;
  // Register indices; the bus carries byte addresses, so a byte address is the index times four.
  localparam logic [7:0] IDX_STACK_TOP = 8'h81;
  localparam logic [7:0] IDX_PTR_LOW = 8'h82;
  localparam logic [7:0] IDX_PTR_HIGH = 8'h83;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_STATUS_WORD = 8'hd0;
  localparam logic [7:0] IDX_MAIN_ACC = 8'he0;
  localparam logic [7:0] IDX_SECOND_ACC = 8'hf0;
  // Extra register holding the power state and hardware event controls.
  localparam logic [7:0] IDX_POWER_STATE = 8'h40;
  localparam int ADDR_W = 10;
  // Reset values.
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [15:0] RST_RESTART_PC = 16'h0000;
  // Status word field positions.
  localparam int SW_CARRY = 7;
  localparam int SW_HALF = 6;
  localparam int SW_USER_A = 5;
  localparam int SW_BANK_HI = 4;
  localparam int SW_BANK_LO = 3;
  localparam int SW_OVF = 2;
  localparam int SW_USER_B = 1;
  localparam int SW_PARITY = 0;
  // Power control field positions.
  localparam int PC_STOP = 1;
  localparam int PC_IDLE = 0;
  // Power state register field position of the clock-loss enable.
  localparam int PS_LOSS_EN = 2;
  // Bytes in one register bank.
  localparam logic [4:0] BANK_SIZE = 5'h08;
  // Arithmetic operation codes from the core datapath.
  typedef enum logic [2:0] {
    CRPM_OP_NONE = 3'h0,
    CRPM_OP_ADD = 3'h1,
    CRPM_OP_ADDC = 3'h2,
    CRPM_OP_SUBB = 3'h3,
    CRPM_OP_MUL = 3'h4,
    CRPM_OP_DIV = 3'h5,
    CRPM_OP_OTHER = 3'h6
  } crpm_op_t;
  // Power states, Gray coded along run, idle, stop.
  typedef enum logic [1:0] {
    CRPM_RUN = 2'b00,
    CRPM_IDLE = 2'b01,
    CRPM_STOP = 2'b11
  } crpm_pwr_t;
  // One arithmetic result from the datapath.
  typedef struct packed {
    logic valid;
    crpm_op_t op;
    logic [7:0] acc;
    logic [7:0] second;
    logic carry;
    logic half;
    logic ovf_cond;
  } crpm_arith_t;
  // Core-side events that touch the registers.
  typedef struct packed {
    logic push;
    logic instr_done;
    logic irq_pending;
    logic watchdog_reset;
    logic clock_loss_reset;
  } crpm_core_ev_t;
endpackage : crpm_pkg

/* File: core/crpm_power_fsm.sv */
// Power mode state machine for idle and stop entry and exit.
`timescale 1ns/1ps
module crpm_power_fsm (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic idle_req_in,
  input wire logic stop_req_in,
  input wire logic instr_done_in,
  input wire logic irq_pending_in,
  output crpm_pkg::crpm_pwr_t state_out,
  output logic idle_armed_out
);
  import crpm_pkg::*;
  crpm_pwr_t state;
  crpm_pwr_t next_state;
  logic idle_armed;
  logic stop_armed;

  // Requests wait until the writing instruction completes; stop beats idle.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_armed <= 1'b0;
      stop_armed <= 1'b0;
    end else if (state == CRPM_RUN) begin
      if (stop_req_in) begin
        stop_armed <= 1'b1;
      end else if (instr_done_in) begin
        stop_armed <= 1'b0;
      end
      if (idle_req_in) begin
        idle_armed <= 1'b1;
      end else if (instr_done_in) begin
        idle_armed <= 1'b0;
      end
    end else begin
      idle_armed <= 1'b0;
      stop_armed <= 1'b0;
    end
  end

  // Idle leaves on an interrupt; stop leaves only through reset.
  // A request written in the very cycle the instruction ends counts at once.
  always_comb begin
    next_state = state;
    case (state)
      CRPM_RUN: begin
        if ((stop_armed || stop_req_in) && instr_done_in) begin
          next_state = CRPM_STOP;
        end else if ((idle_armed || idle_req_in) && instr_done_in) begin
          next_state = CRPM_IDLE;
        end
      end
      CRPM_IDLE: begin
        if (irq_pending_in) begin
          next_state = CRPM_RUN;
        end
      end
      CRPM_STOP: begin
        next_state = CRPM_STOP;
      end
      default: begin
        next_state = CRPM_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= CRPM_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign state_out = state;
  assign idle_armed_out = idle_armed | stop_armed;
endmodule : crpm_power_fsm

/* File: tb/crpm_core_regs_tb.sv */
// Self-checking bench for the core register and power mode block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module crpm_core_regs_tb;
  import crpm_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [1:0] avs_response_out;
  crpm_arith_t ar_s = '0;
  crpm_core_ev_t ev = '0;
  logic [15:0] indirect_pointer16_out;
  logic [4:0] bank_base_out;
  logic [7:0] push_addr_out;
  logic push_ack_out;
  logic core_halt_out;
  logic osc_stop_out;
  logic core_reset_req_out;
  logic [15:0] restart_pc_out;
  logic [33:0] exp_q[$];
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] sp, acc, sec, lo, hi, v;
  logic [7:1] pw;
  crpm_op_t op;
  logic [7:0] zero_idx[6] = '{IDX_PTR_LOW, IDX_PTR_HIGH, IDX_POWER_CONTROL, IDX_STATUS_WORD, IDX_MAIN_ACC,
                              IDX_SECOND_ACC};

  crpm_core_regs dut (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .arith_in(ar_s), .core_ev_in(ev),
    .indirect_pointer16_out(indirect_pointer16_out), .bank_base_out(bank_base_out),
    .push_addr_out(push_addr_out), .push_ack_out(push_ack_out), .core_halt_out(core_halt_out),
    .osc_stop_out(osc_stop_out), .core_reset_req_out(core_reset_req_out), .restart_pc_out(restart_pc_out));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Read monitor takes the oldest note whenever a read completes, so the driver never compares itself.
  always @(posedge core_clk_in) begin : mon
    logic [33:0] e;
    if (avs_read && avs_waitrequest_out === 1'b0) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
      `CHK("read data", e, {avs_response_out, avs_readdata_out})
    end
  end

  // A hang counts as a mismatch and still reaches the one verdict.
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // One bus cycle; the request stands until waitrequest is sampled low.
  task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {$urandom() & 32'hffffff00} | 32'(d);
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] ex, input logic [1:0] rsp = 2'h0);
    exp_q.push_back({rsp, 24'h0, ex});
    bus(idx, 1'b0, 8'h00);
  endtask : rd

  // Event pulse of one cycle; the interrupt level is driven separately.
  task automatic evp(input logic [4:0] m);
    @(posedge core_clk_in);
    ev <= crpm_core_ev_t'(m);
    @(posedge core_clk_in);
    ev <= '0;
  endtask : evp

  task automatic alu(input crpm_op_t o, input logic [7:0] a, b, input logic c, h, f);
    @(posedge core_clk_in);
    ar_s <= '{valid: 1'b1, op: o, acc: a, second: b, carry: c, half: h, ovf_cond: f};
    @(posedge core_clk_in);
    ar_s <= '0;
  endtask : alu

  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : waitc

  task automatic reset_dut();
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    ev <= '0;
    waitc(8);
    reset_n_in <= 1'b1;
  endtask : reset_dut

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  // Main sequence.
  initial begin
    void'($urandom(39));
    reset_dut();
    rd(IDX_STACK_TOP, RST_STACK_TOP);
    foreach (zero_idx[i]) rd(zero_idx[i], RST_ZERO);
    rd(8'h85, 8'h00, 2'h2);
    done("reset and unmapped");
    // Pointer bytes pair into the 16-bit output, low byte below.
    lo = 8'($urandom());
    hi = 8'($urandom());
    wr(IDX_PTR_LOW, lo);
    wr(IDX_PTR_HIGH, hi);
    waitc(2);
    `CHK("pointer16", {hi, lo}, indirect_pointer16_out)
    rd(IDX_PTR_HIGH, hi);
    done("pointer");
    // Every bank code, with user flags carried through and parity read-only.
    acc = 8'($urandom());
    wr(IDX_MAIN_ACC, acc);
    for (int b = 0; b < 4; b++) begin
      v = 8'($urandom());
      v[4:3] = 2'(b);
      wr(IDX_STATUS_WORD, v);
      pw = v[7:1];
      rd(IDX_STATUS_WORD, {pw, ^acc});
      `CHK("bank base", 5'(b * 8), bank_base_out)
    end
    done("status word");
    // Each arithmetic code but CRPM_OP_NONE once; flags follow the datapath, user flags and bank untouched.
    sec = RST_ZERO;
    for (int k = 1; k <= 6; k++) begin
      op = crpm_op_t'(k);
      v = 8'($urandom());
      acc = 8'($urandom());
      alu(op, acc, v, k[0], k[1], ~k[0]);
      if (op == CRPM_OP_MUL || op == CRPM_OP_DIV) sec = v;
      pw[7] = (op <= CRPM_OP_SUBB) ? k[0] : 1'b0;
      pw[6] = (op <= CRPM_OP_SUBB) ? k[1] : 1'b0;
      if (op != CRPM_OP_OTHER) pw[2] = ~k[0];
      rd(IDX_STATUS_WORD, {pw, ^acc});
      rd(IDX_SECOND_ACC, sec);
    end
    done("arithmetic flags");
    // Two pushes in a row, each address one above the pointer it started from.
    sp = 8'($urandom());
    wr(IDX_STACK_TOP, sp);
    for (int k = 0; k < 2; k++) begin
      evp(5'h10);
      for (int n = 0; n < 10 && push_ack_out !== 1'b1; n++) @(posedge core_clk_in);
      `CHK("push ack", 1'b1, push_ack_out)
      sp = sp + 8'h01;
      `CHK("push address", sp, push_addr_out)
    end
    rd(IDX_STACK_TOP, sp);
    done("push");
    // Idle: halt after the instruction, registers frozen, interrupt resumes.
    wr(IDX_POWER_CONTROL, 8'h01);
    rd(IDX_POWER_CONTROL, 8'h00);
    evp(5'h08);
    waitc(3);
    `CHK("halt in idle", 1'b1, core_halt_out)
    `CHK("osc in idle", 1'b0, osc_stop_out)
    rd(IDX_POWER_STATE, 8'h01);
    wr(IDX_MAIN_ACC, ~acc);
    rd(IDX_MAIN_ACC, acc);
    rd(IDX_STACK_TOP, sp);
    evp(5'h01);
    waitc(3);
    `CHK("no loss reset when disabled", 1'b0, core_reset_req_out)
    @(posedge core_clk_in);
    ev.irq_pending <= 1'b1;
    waitc(3);
    `CHK("resume on interrupt", 1'b0, core_halt_out)
    ev.irq_pending <= 1'b0;
    rd(IDX_POWER_STATE, 8'h00);
    done("idle and interrupt");
    // Watchdog in idle asks for a reset; the reset restarts at zero.
    wr(IDX_POWER_CONTROL, 8'h01);
    evp(5'h08);
    waitc(3);
    evp(5'h02);
    waitc(1);
    `CHK("watchdog reset request", 1'b1, core_reset_req_out)
    reset_dut();
    `CHK("restart address", 16'h0000, restart_pc_out)
    `CHK("halt cleared", 1'b0, core_halt_out)
    rd(IDX_STACK_TOP, RST_STACK_TOP);
    done("watchdog in idle");
    // Both bits at once picks stop; an interrupt does not end it, a clock-loss reset does.
    wr(IDX_POWER_STATE, 8'h04);
    // The instruction end coincides with the accepting edge of the write.
    @(posedge core_clk_in);
    ev.instr_done <= 1'b1;
    wr(IDX_POWER_CONTROL, 8'h03);
    ev.instr_done <= 1'b0;
    rd(IDX_POWER_CONTROL, 8'h00);
    evp(5'h08);
    waitc(3);
    `CHK("stop oscillator", 1'b1, osc_stop_out)
    rd(IDX_POWER_STATE, 8'h07);
    @(posedge core_clk_in);
    ev.irq_pending <= 1'b1;
    waitc(6);
    `CHK("stop holds past interrupt", 1'b1, osc_stop_out)
    ev.irq_pending <= 1'b0;
    evp(5'h01);
    waitc(1);
    `CHK("loss reset request", 1'b1, core_reset_req_out)
    reset_dut();
    `CHK("stop left by reset", 1'b0, osc_stop_out)
    `CHK("restart after stop", 16'h0000, restart_pc_out)
    rd(IDX_POWER_STATE, 8'h00);
    done("stop"); // No suspend entry is made, so no reference setup is owed.
    waitc(2);
    conclude();
  end
endmodule : crpm_core_regs_tb
